// ==== verilog/wdt_map.vh ====
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// ****************************************************************
// Register word indexes and byte addresses
// ****************************************************************
`define WDT_CSR_INDEX 16'hffbe
`define WDT_CNT_INDEX 16'hffbf
`define WDT_CSR_ADDR 18'h3fef8
`define WDT_CNT_ADDR 18'h3fefc
`define WDT_ISTAT_ADDR 18'h00000
`define WDT_IEN_ADDR 18'h00004
`define WDT_ICLR_ADDR 18'h00008

// ****************************************************************
// Control/status fields
// ****************************************************************
`define WDT_CAUSE_BIT 0
`define WDT_RUN_BIT 2
`define WDT_REGWE_BIT 4
`define WDT_CNTWE_BIT 6
`define WDT_INHIBIT_MASK 8'haa
`define WDT_CSR_RESET 8'haa
`define WDT_CNT_RESET 8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define WDT_DIVIDE 8192
`define WDT_RESET_CYCLES 512

`endif

// ==== verilog/system_watchdog_timer.v ====
// Notes on behaviour
// - Counter advances once per 8192 clocks, only while running.
// - Wrap from ff to 00 raises chip reset and sets cause flag.
// - Watchdog reset held exactly 512 oscillator cycles.
// - Overflow happens on the tick after reaching ff.
// - Inhibit bits 7,5,3,1 read as 1 and store nothing.
// - Even bit written only when inhibit bit above it is 0.
// - Counter writes take effect only with counter write enable set.
// - Run bit and cause flag writable only with register write enable.
// - Count while run bit is 1; set by inhibit 0, run 1.
// - Run bit clears on reset or enabled write of 0 with inhibit 0.
// - Cause flag clears on pin reset or enabled write of 0 with inhibit 0.
// - Counter write loads value; counting continues upward from it.
// - Pin reset gives counter 00 and control/status aa.
`include "wdt_map.vh"

module system_watchdog_timer
(
    // Clock and external reset pin
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [17:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Chip reset and interrupt
    output reg wdt_reset_out,
    output reg irq
);

    // ****************************************************************
    // State
    // ****************************************************************
    reg [12:0] div_r;
    reg [12:0] div_nxt;
    reg [7:0] cnt_r;
    reg [7:0] cnt_nxt;
    reg cnt_we_r;
    reg cnt_we_nxt;
    reg reg_we_r;
    reg reg_we_nxt;
    reg run_r;
    reg run_nxt;
    reg cause_r;
    reg cause_nxt;
    reg [9:0] rst_cnt_r;
    reg [9:0] rst_cnt_nxt;
    reg reset_out_nxt;
    reg [1:0] istat_r;
    reg [1:0] istat_nxt;
    reg [1:0] ien_r;
    reg [1:0] ien_nxt;
    reg irq_nxt;
    reg pready_nxt;
    reg pslverr_nxt;
    reg [31:0] prdata_nxt;

    // Terminal counts, cut to the counter widths on purpose
    localparam integer DIV_LAST_I = `WDT_DIVIDE - 1;
    localparam integer RST_LAST_I = `WDT_RESET_CYCLES - 1;
    localparam [12:0] DIV_LAST = DIV_LAST_I[12:0];
    localparam [9:0] RST_LAST = RST_LAST_I[9:0];

    wire acc = psel & penable & pready;
    wire wr = acc & pwrite & pstrb[0];
    wire [7:0] wd = pwdata[7:0];
    wire wr_csr = wr & (paddr == `WDT_CSR_ADDR);
    wire wr_cnt = wr & (paddr == `WDT_CNT_ADDR);
    wire wr_ien = wr & (paddr == `WDT_IEN_ADDR);
    wire wr_iclr = wr & (paddr == `WDT_ICLR_ADDR);
    wire tick = run_r & (div_r == DIV_LAST);
    wire ovf = tick & (cnt_r == 8'hff);
    wire in_rst = wdt_reset_out;
    // Last cycle of the chip reset request
    wire rst_end = in_rst & (rst_cnt_r == RST_LAST);
    // Interrupt events: bit0 overflow, bit1 reset release
    wire [1:0] ev = {rst_end, ovf};
    wire [7:0] csr_rd = `WDT_INHIBIT_MASK | {1'b0, cnt_we_r, 1'b0,
        reg_we_r, 1'b0, run_r, 1'b0, cause_r};

    function mapped;
        input [17:0] a;
        begin
            mapped = (a == `WDT_CSR_ADDR) | (a == `WDT_CNT_ADDR) |
                (a == `WDT_ISTAT_ADDR) | (a == `WDT_IEN_ADDR) |
                (a == `WDT_ICLR_ADDR);
        end
    endfunction

    // Even bit may change only with its inhibit bit written as 0
    function guard;
        input [7:0] d;
        input integer bitn;
        begin
            guard = ~d[bitn + 1];
        end
    endfunction

    // ****************************************************************
    // Prescaler and counter
    // ****************************************************************
    always @*
    begin
        div_nxt = div_r + 13'h0001;
        cnt_nxt = cnt_r;
        if (ovf | in_rst)
        begin
            // Chip reset from the watchdog restarts the count
            div_nxt = 13'h0000;
            cnt_nxt = `WDT_CNT_RESET;
        end
        else
        begin
            // Prescaler stays at zero while stopped
            if (!run_r | tick)
                div_nxt = 13'h0000;
            // A load wins over a tick in the same cycle
            if (wr_cnt & cnt_we_r)
                cnt_nxt = wd;
            else if (tick)
                cnt_nxt = cnt_r + 8'h01;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_r <= 13'h0000;
            cnt_r <= `WDT_CNT_RESET;
        end
        else
        begin
            div_r <= div_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ****************************************************************
    // Control/status register
    // ****************************************************************
    always @*
    begin
        cnt_we_nxt = cnt_we_r;
        reg_we_nxt = reg_we_r;
        run_nxt = run_r;
        cause_nxt = cause_r;
        if (ovf | in_rst)
        begin
            // Chip reset keeps the cause flag for software
            cnt_we_nxt = 1'b0;
            reg_we_nxt = 1'b0;
            run_nxt = 1'b0;
            cause_nxt = 1'b1;
        end
        else if (wr_csr)
        begin
            if (guard(wd, `WDT_CNTWE_BIT))
                cnt_we_nxt = wd[`WDT_CNTWE_BIT];
            if (guard(wd, `WDT_REGWE_BIT))
                reg_we_nxt = wd[`WDT_REGWE_BIT];
            // Uses the write enable held before this write
            if (reg_we_r & guard(wd, `WDT_RUN_BIT))
                run_nxt = wd[`WDT_RUN_BIT];
            if (reg_we_r & guard(wd, `WDT_CAUSE_BIT))
                cause_nxt = wd[`WDT_CAUSE_BIT];
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_we_r <= 1'b0;
            reg_we_r <= 1'b0;
            run_r <= 1'b0;
            cause_r <= 1'b0;
        end
        else
        begin
            cnt_we_r <= cnt_we_nxt;
            reg_we_r <= reg_we_nxt;
            run_r <= run_nxt;
            cause_r <= cause_nxt;
        end
    end

    // ****************************************************************
    // Internal reset pulse
    // ****************************************************************
    always @*
    begin
        reset_out_nxt = wdt_reset_out;
        rst_cnt_nxt = rst_cnt_r;
        if (ovf)
        begin
            reset_out_nxt = 1'b1;
            rst_cnt_nxt = 10'h000;
        end
        else if (rst_end)
            reset_out_nxt = 1'b0;
        else if (in_rst)
            rst_cnt_nxt = rst_cnt_r + 10'h001;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdt_reset_out <= 1'b0;
            rst_cnt_r <= 10'h000;
        end
        else
        begin
            wdt_reset_out <= reset_out_nxt;
            rst_cnt_r <= rst_cnt_nxt;
        end
    end

    // ****************************************************************
    // Interrupts: bit0 overflow, bit1 reset release
    // ****************************************************************
    always @*
    begin
        // A new event wins over a clear in the same cycle
        istat_nxt = istat_r | ev;
        if (wr_iclr)
            istat_nxt = (istat_r & ~wd[1:0]) | ev;
        ien_nxt = ien_r;
        if (wr_ien)
            ien_nxt = wd[1:0];
        irq_nxt = |(istat_r & ien_r);
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            istat_r <= 2'h0;
            ien_r <= 2'h0;
            irq <= 1'b0;
        end
        else
        begin
            istat_r <= istat_nxt;
            ien_r <= ien_nxt;
            irq <= irq_nxt;
        end
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    always @*
    begin
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata;
        // Answer every setup cycle in the following access cycle
        if (psel & !penable)
        begin
            pready_nxt = 1'b1;
            pslverr_nxt = ~mapped(paddr);
            prdata_nxt = 32'h00000000;
            if (!pwrite)
            begin
                case (paddr)
                    `WDT_CSR_ADDR:
                        prdata_nxt[7:0] = csr_rd;
                    `WDT_CNT_ADDR:
                        prdata_nxt[7:0] = cnt_r;
                    `WDT_ISTAT_ADDR:
                        prdata_nxt[1:0] = istat_r;
                    `WDT_IEN_ADDR:
                        prdata_nxt[1:0] = ien_r;
                    default:
                        prdata_nxt = 32'h00000000;
                endcase
            end
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
            prdata <= prdata_nxt;
        end
    end

endmodule

// ==== tb/system_watchdog_timer_sva.sv ====
`include "wdt_map.vh"

module system_watchdog_timer_sva (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Bus
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [17:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Chip reset and interrupt
    input wire wdt_reset_out,
    input wire irq
);
    // ******
    // Checks
    // ******
    logic [9:0] held_r;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Counts how long the chip reset request has stood
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            held_r <= 10'h0;
        else
            held_r <= wdt_reset_out ? held_r + 10'h1 : 10'h0;
    property p_answer; psel && !penable |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no ready");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("long ready");
    property p_err; pready && (paddr == `WDT_CSR_ADDR ||
        paddr == `WDT_CNT_ADDR) |-> !pslverr; endproperty
    a_err: assert property (p_err) else $error("bad error");
    property p_upper; pready && !pwrite |-> prdata[31:8] == 24'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper bits");
    property p_inh; pready && !pwrite && paddr == `WDT_CSR_ADDR |->
        (prdata[7:0] & 8'haa) == 8'haa; endproperty
    a_inh: assert property (p_inh) else $error("inhibit bits");
    property p_hold; $fell(wdt_reset_out) |-> held_r == 10'h200;
    endproperty
    a_hold: assert property (p_hold) else $error("reset length");
    property p_wdcnt; pready && !pwrite && paddr == `WDT_CNT_ADDR &&
        $past(wdt_reset_out) |-> prdata[7:0] == 8'h00; endproperty
    a_wdcnt: assert property (p_wdcnt) else $error("count kept");
    property p_wdcsr; pready && !pwrite && paddr == `WDT_CSR_ADDR &&
        $past(wdt_reset_out) |-> prdata[7:0] == 8'hab; endproperty
    a_wdcsr: assert property (p_wdcsr) else $error("csr");
    c_ovf: cover property ($rose(wdt_reset_out));
    c_err: cover property (pslverr);
    c_irq: cover property ($fell(irq));
endmodule

bind system_watchdog_timer system_watchdog_timer_sva chk_i (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .wdt_reset_out, .irq);

// ==== tb/system_watchdog_timer_bench.sv ====
`include "wdt_map.vh"

module system_watchdog_timer_bench;
timeunit 1ns;
timeprecision 1ps;
logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
logic wdt_reset_out, irq;
logic [17:0] paddr;
logic [31:0] pwdata, prdata, rd;
logic [3:0] pstrb;
int n_errors, checked, t;

system_watchdog_timer DUT (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .wdt_reset_out, .irq);

// *********
// Bus tasks
// *********
task xfer(input logic w, input logic [17:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
        @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
endtask

task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
        n_errors++;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
endtask

task rc(input logic [17:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
endtask

task wc(input logic [17:0] a, input logic [7:0] d, input logic [7:0] e);
    xfer(1'b1, a, d);
    rc(a, e);
endtask

task ic(input logic e);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, {31'h0, e});
endtask

task end_of_test;
    if (n_errors == 0 && checked > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask

// *****
// Tests
// *****
initial
begin
    pclk = 1'b0;
    forever
        #12.5 pclk = ~pclk;
end

initial
begin
    #1ms;
    n_errors++;
    end_of_test;
end

initial
begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(`WDT_CSR_ADDR, 8'haa);
    rc(`WDT_CNT_ADDR, 8'h00);
    xfer(1'b0, 18'h00100, 8'h00);
    chk({31'h0, er}, 32'h1);
    wc(`WDT_CNT_ADDR, 8'h55, 8'h00);
    wc(`WDT_CSR_ADDR, 8'h05, 8'haa);
    wc(`WDT_CSR_ADDR, 8'h6a, 8'hea);
    wc(`WDT_CNT_ADDR, 8'h55, 8'h55);
    pstrb <= 4'h0;
    xfer(1'b1, `WDT_CNT_ADDR, 8'h33);
    pstrb <= 4'hf;
    rc(`WDT_CNT_ADDR, 8'h55);
    wc(`WDT_CSR_ADDR, 8'h9a, 8'hfa);
    wc(`WDT_CSR_ADDR, 8'ha6, 8'hfe);
    wc(`WDT_CSR_ADDR, 8'ha2, 8'hfa);
    wc(`WDT_CNT_ADDR, 8'hfe, 8'hfe);
    xfer(1'b1, `WDT_IEN_ADDR, 8'h03);
    xfer(1'b1, `WDT_CSR_ADDR, 8'ha6);
    t = 0;
    while (wdt_reset_out !== 1'b1)
    begin
        @(posedge pclk);
        t++;
    end
    chk({31'h0, t > 16375 && t < 16395}, 32'h1);
    rc(`WDT_CSR_ADDR, 8'hab);
    rc(`WDT_CNT_ADDR, 8'h00);
    rc(`WDT_ISTAT_ADDR, 8'h01);
    ic(1'b1);
    xfer(1'b1, `WDT_IEN_ADDR, 8'h00);
    ic(1'b0);
    xfer(1'b1, `WDT_IEN_ADDR, 8'h03);
    while (wdt_reset_out !== 1'b0)
        @(posedge pclk);
    rc(`WDT_ISTAT_ADDR, 8'h03);
    xfer(1'b1, `WDT_ICLR_ADDR, 8'h03);
    ic(1'b0);
    rc(`WDT_ISTAT_ADDR, 8'h00);
    wc(`WDT_CSR_ADDR, 8'h9a, 8'hbb);
    wc(`WDT_CSR_ADDR, 8'ha8, 8'hba);
    wc(`WDT_CSR_ADDR, 8'h6a, 8'hfa);
    wc(`WDT_CNT_ADDR, 8'hff, 8'hff);
    xfer(1'b1, `WDT_CSR_ADDR, 8'ha6);
    t = 0;
    while (wdt_reset_out !== 1'b1)
    begin
        @(posedge pclk);
        t++;
    end
    chk({31'h0, t > 8183 && t < 8203}, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(`WDT_CSR_ADDR, 8'haa);
    rc(`WDT_CNT_ADDR, 8'h00);
    end_of_test;
end
endmodule
